// File: src/gcr_top.sv
// Purpose: chip-level configuration register bank on a classic Wishbone slave
// Assumes: two async active-low resets, bus well and standby well
// Notes: one-wait-state ack; unmapped indices read zero and ignore writes
`timescale 1ns/1ns
`include "gcr_map.svh"

// Operation
// - Writing one to bit 0 of the soft reset register pulses a chip soft reset.
// - Logical device number register, 8-bit read/write, resets to zero, selects a device.
// - First type register bit 5 sets serial A edge/level, bit 4 serial B.
// - Second type register: bit 6 watchdog, bits 5/4 serial C/D, bit 1 SMI.
// - Upper polarity register sets channels 15..8; one means active low.
// - Lower polarity register sets channels 7..0; one means active low.
// - Type and polarity registers are accessible only while global option bit 4 is set.
// - Type and polarity registers reset to all ones.
// - Pin 32 is clock input, gpio bit 67, or reserved from two selects.
// - Pins 33-40 gpio plus port80 when strapped, else gpio/serial C; 41-48 gpio/serial D.
// - Pin function register lives in standby well, reset value 10h.
// - Chip identification high byte is read only and unaffected by reset.
// - Chip identification low byte: fixed upper nibble, revision lower nibble.
// - Power-down bits 5/4 power serial B/A when set; register resets to ones.
// - Clearing power-down bit 1 puts the whole chip into power-down at once.
// - Address default bit 0 picks default address values or none.
// - Tristate bits 5..2 tristate serial D, C, B, A; register resets to zero.
// - Strapped global option resets to zero except bit 6 taken from a strap.
// - Standby global option lives in standby well and resets to zero.
// - Port80 strap result readable at strap result bit 3; routes port80 output.
module gcr_top #(
  parameter logic [7:0] CHIP_ID_HIGH = 8'hA5, // Arbitrary value
  parameter logic [3:0] CHIP_ID_LOW_FIXED = 4'h6, // Arbitrary value
  parameter logic [3:0] CHIP_REVISION = 4'h1 // Arbitrary value
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic standby_power_good_reset_n_i,
  input wire gcr_pkg::gcr_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_option_strap_i,
  input wire logic port80_serial_out_strap_i,
  output logic soft_reset_o,
  output logic [7:0] logical_device_o,
  output gcr_pkg::gcr_irq_level_t irq_level_o,
  output logic [15:0] irq_polarity_low_o,
  output gcr_pkg::gcr_pin_mux_t pin_mux_o,
  output logic serial_a_power_on_o,
  output logic serial_b_power_on_o,
  output logic immediate_power_down_o,
  output logic pnp_default_select_o,
  output logic serial_a_tristate_o,
  output logic serial_b_tristate_o,
  output logic serial_c_tristate_o,
  output logic serial_d_tristate_o
);
  localparam int MAIN_N = 8;
  localparam int M_LDN = 0;
  localparam int M_TYPE_A = 1;
  localparam int M_TYPE_B = 2;
  localparam int M_POL_H = 3;
  localparam int M_POL_L = 4;
  localparam int M_PD = 5;
  localparam int M_ADDR = 6;
  localparam int M_TRI = 7;
  localparam logic [7:0] MAIN_IDX [MAIN_N] = '{
    `GCR_IDX_LDN, `GCR_IDX_TYPE_A, `GCR_IDX_TYPE_B, `GCR_IDX_POL_HIGH,
    `GCR_IDX_POL_LOW, `GCR_IDX_POWER_DOWN, `GCR_IDX_ADDR_DEF, `GCR_IDX_TRISTATE};
  localparam logic [7:0] MAIN_RST [MAIN_N] = '{
    `GCR_RST_ZERO, `GCR_RST_ONES, `GCR_RST_ONES, `GCR_RST_ONES,
    `GCR_RST_ONES, `GCR_RST_ONES, `GCR_RST_ZERO, `GCR_RST_ZERO};

  // Type and polarity registers sit behind the option gate
  function automatic logic is_gated(input logic [7:0] idx);
    is_gated = (idx == `GCR_IDX_TYPE_A) || (idx == `GCR_IDX_TYPE_B) ||
      (idx == `GCR_IDX_POL_HIGH) || (idx == `GCR_IDX_POL_LOW);
  endfunction

  function automatic logic access_ok(input logic [7:0] idx, input logic gate);
    access_ok = !is_gated(idx) || gate;
  endfunction

  logic ack_q;
  logic [31:0] dat_q;
  logic soft_reset_q;
  logic [7:0] main_q [MAIN_N];
  logic [7:0] gopt_strap_q;
  logic strap_taken_q;
  logic [7:0] pin_func_q;
  logic [7:0] gopt_stby_q;
  logic [7:0] strap_result_q;
  logic strap_sb_taken_q;

  wire req_live = wb_req_i.cyc && wb_req_i.stb;
  wire req_new = req_live && !ack_q;
  wire [7:0] acc_idx = {2'h0, wb_req_i.adr[7:2]};
  wire [7:0] wr_byte = wb_req_i.dat[7:0];
  // Writes land only on the edge where ack is seen high
  wire wr_fire = req_live && ack_q && wb_req_i.we && wb_req_i.sel[0];
  wire gate_on = gopt_strap_q[`GCR_BIT_GATE];
  wire acc_ok = access_ok(acc_idx, gate_on);
  wire wr_ok = wr_fire && acc_ok;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req_new;
    end
  end

  wire [7:0] rd_acc [MAIN_N+1];
  assign rd_acc[0] = 8'h00;

  genvar g;
  generate
    for (g = 0; g < MAIN_N; g++)
    begin : g_main
      wire hit = wr_ok && (acc_idx == MAIN_IDX[g]);
      always_ff @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          main_q[g] <= MAIN_RST[g];
        end
        else if (hit)
        begin
          main_q[g] <= wr_byte;
        end
      end
      assign rd_acc[g+1] = rd_acc[g] | ((acc_idx == MAIN_IDX[g]) ? main_q[g] : 8'h00);
    end
  endgenerate

  // Soft reset pulses for one cycle; the register itself reads zero
  wire soft_hit = wr_fire && (acc_idx == `GCR_IDX_SOFT_RESET);
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      soft_reset_q <= 1'b0;
    end
    else
    begin
      soft_reset_q <= soft_hit && wr_byte[`GCR_BIT_SOFT_RESET];
    end
  end

  // Strap is sampled on the first edge after release, never under reset
  wire gopt_hit = wr_fire && (acc_idx == `GCR_IDX_GOPT_STRAP);
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gopt_strap_q <= `GCR_RST_ZERO;
      strap_taken_q <= 1'b0;
    end
    else if (gopt_hit)
    begin
      gopt_strap_q <= wr_byte;
      strap_taken_q <= 1'b1;
    end
    else if (!strap_taken_q)
    begin
      gopt_strap_q[`GCR_BIT_OPT_STRAP] <= global_option_strap_i;
      strap_taken_q <= 1'b1;
    end
  end

  // Standby well: bus reset leaves these alone
  wire pf_hit = wr_fire && (acc_idx == `GCR_IDX_PIN_FUNC);
  wire gs_hit = wr_fire && (acc_idx == `GCR_IDX_GOPT_STBY);
  wire sr_hit = wr_fire && (acc_idx == `GCR_IDX_STRAP_RESULT);
  always_ff @(posedge clock_i or negedge standby_power_good_reset_n_i)
  begin
    if (!standby_power_good_reset_n_i)
    begin
      pin_func_q <= `GCR_RST_PIN_FUNC;
      gopt_stby_q <= `GCR_RST_ZERO;
    end
    else
    begin
      if (pf_hit)
      begin
        pin_func_q <= wr_byte;
      end
      if (gs_hit)
      begin
        gopt_stby_q <= wr_byte;
      end
    end
  end

  always_ff @(posedge clock_i or negedge standby_power_good_reset_n_i)
  begin
    if (!standby_power_good_reset_n_i)
    begin
      strap_result_q <= `GCR_RST_ZERO;
      strap_sb_taken_q <= 1'b0;
    end
    else if (sr_hit)
    begin
      strap_result_q <= wr_byte;
      strap_sb_taken_q <= 1'b1;
    end
    else if (!strap_sb_taken_q)
    begin
      strap_result_q[`GCR_BIT_PORT80_STRAP] <= port80_serial_out_strap_i;
      strap_sb_taken_q <= 1'b1;
    end
  end

  wire [7:0] id_low = {CHIP_ID_LOW_FIXED, CHIP_REVISION};
  wire [7:0] rd_misc =
    (acc_idx == `GCR_IDX_PIN_FUNC) ? pin_func_q :
    (acc_idx == `GCR_IDX_ID_HIGH) ? CHIP_ID_HIGH :
    (acc_idx == `GCR_IDX_ID_LOW) ? id_low :
    (acc_idx == `GCR_IDX_GOPT_STRAP) ? gopt_strap_q :
    (acc_idx == `GCR_IDX_GOPT_STBY) ? gopt_stby_q :
    (acc_idx == `GCR_IDX_STRAP_RESULT) ? strap_result_q : 8'h00;
  // Gated registers read zero while closed
  wire [7:0] rd_value = acc_ok ? (rd_acc[MAIN_N] | rd_misc) : 8'h00;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dat_q <= 32'h00000000;
    end
    else if (req_new && !wb_req_i.we)
    begin
      dat_q <= {24'h000000, rd_value};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign soft_reset_o = soft_reset_q;
  assign logical_device_o = main_q[M_LDN];

  assign irq_level_o.serial_a = main_q[M_TYPE_A][`GCR_BIT_TYPE_SER_A];
  assign irq_level_o.serial_b = main_q[M_TYPE_A][`GCR_BIT_TYPE_SER_B];
  assign irq_level_o.watchdog_timeout_irq = main_q[M_TYPE_B][`GCR_BIT_TYPE_WDT];
  assign irq_level_o.serial_c = main_q[M_TYPE_B][`GCR_BIT_TYPE_SER_C];
  assign irq_level_o.serial_d = main_q[M_TYPE_B][`GCR_BIT_TYPE_SER_D];
  assign irq_level_o.smi = main_q[M_TYPE_B][`GCR_BIT_TYPE_SMI];
  assign irq_polarity_low_o = {main_q[M_POL_H], main_q[M_POL_L]};

  // Pin 32: standby select overrides the pin function bit
  assign pin_mux_o.pin32 = gopt_stby_q[`GCR_BIT_PIN32_RSVD] ? gcr_pkg::gcr_pin32_reserved :
    pin_func_q[`GCR_BIT_PIN32_GPIO] ? gcr_pkg::gcr_pin32_gpio :
    gcr_pkg::gcr_pin32_clock;
  assign pin_mux_o.pins33_40 =
    strap_result_q[`GCR_BIT_PORT80_STRAP] ? gcr_pkg::gcr_pins33_gpio_port80 :
    pin_func_q[`GCR_BIT_PINS33_SER] ? gcr_pkg::gcr_pins33_serial_c :
    gcr_pkg::gcr_pins33_gpio;
  assign pin_mux_o.pins41_48 = pin_func_q[`GCR_BIT_PINS41_SER] ?
    gcr_pkg::gcr_pins41_serial_d : gcr_pkg::gcr_pins41_gpio;

  assign serial_a_power_on_o = main_q[M_PD][`GCR_BIT_PD_SER_A];
  assign serial_b_power_on_o = main_q[M_PD][`GCR_BIT_PD_SER_B];
  assign immediate_power_down_o = !main_q[M_PD][`GCR_BIT_PD_IMMEDIATE];
  assign pnp_default_select_o = main_q[M_ADDR][`GCR_BIT_PNP_DEFAULT];
  assign serial_a_tristate_o = main_q[M_TRI][`GCR_BIT_TRI_A];
  assign serial_b_tristate_o = main_q[M_TRI][`GCR_BIT_TRI_B];
  assign serial_c_tristate_o = main_q[M_TRI][`GCR_BIT_TRI_C];
  assign serial_d_tristate_o = main_q[M_TRI][`GCR_BIT_TRI_D];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i || !standby_power_good_reset_n_i);

  a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_request: assert property (req_new |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_soft_reset_pulse: assert property (
    soft_hit && wr_byte[`GCR_BIT_SOFT_RESET] |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  a_ldn_write_stores: assert property (
    wr_fire && acc_idx == `GCR_IDX_LDN |=> logical_device_o == $past(wr_byte))
    else $error("logical device number not stored");
  a_type_gate_blocks: assert property (
    wr_fire && is_gated(acc_idx) && !gate_on |=> $stable(irq_polarity_low_o) &&
    $stable(irq_level_o))
    else $error("gated register written while closed");
  a_type_a_serial: assert property (
    wr_fire && gate_on && acc_idx == `GCR_IDX_TYPE_A |=>
    irq_level_o.serial_a == $past(wr_byte[`GCR_BIT_TYPE_SER_A]))
    else $error("serial A type not taken");
  a_type_b_watchdog: assert property (
    wr_fire && gate_on && acc_idx == `GCR_IDX_TYPE_B |=>
    irq_level_o.watchdog_timeout_irq == $past(wr_byte[`GCR_BIT_TYPE_WDT]))
    else $error("watchdog type not taken");
  a_pol_high_write: assert property (
    wr_fire && gate_on && acc_idx == `GCR_IDX_POL_HIGH |=>
    irq_polarity_low_o[15:8] == $past(wr_byte))
    else $error("upper polarity not taken");
  a_pin32_reserved: assert property (
    gopt_stby_q[`GCR_BIT_PIN32_RSVD] |-> pin_mux_o.pin32 == gcr_pkg::gcr_pin32_reserved)
    else $error("pin 32 select wrong");
  a_ipd_immediate: assert property (
    wr_fire && acc_idx == `GCR_IDX_POWER_DOWN && !wr_byte[`GCR_BIT_PD_IMMEDIATE] |=>
    immediate_power_down_o)
    else $error("immediate power down missed");
  a_id_high_read: assert property (
    req_new && !wb_req_i.we && acc_idx == `GCR_IDX_ID_HIGH |=>
    wb_ack_o && wb_dat_o[7:0] == CHIP_ID_HIGH)
    else $error("chip id high read wrong");
  a_tristate_a_write: assert property (
    wr_fire && acc_idx == `GCR_IDX_TRISTATE |=>
    serial_a_tristate_o == $past(wr_byte[`GCR_BIT_TRI_A]))
    else $error("serial A tristate not taken");
  a_tristate_bcd_write: assert property (
    wr_fire && acc_idx == `GCR_IDX_TRISTATE |=>
    serial_b_tristate_o == $past(wr_byte[`GCR_BIT_TRI_B]) &&
    serial_c_tristate_o == $past(wr_byte[`GCR_BIT_TRI_C]) &&
    serial_d_tristate_o == $past(wr_byte[`GCR_BIT_TRI_D]))
    else $error("serial B/C/D tristate not taken");
  a_pol_low_write: assert property (
    wr_ok && acc_idx == `GCR_IDX_POL_LOW |=>
    irq_polarity_low_o[7:0] == $past(wr_byte))
    else $error("lower polarity not taken");
  a_type_a_second: assert property (
    wr_ok && acc_idx == `GCR_IDX_TYPE_A |=>
    irq_level_o.serial_b == $past(wr_byte[`GCR_BIT_TYPE_SER_B]))
    else $error("serial B type not taken");
  a_type_b_others: assert property (
    wr_ok && acc_idx == `GCR_IDX_TYPE_B |=>
    irq_level_o.serial_c == $past(wr_byte[`GCR_BIT_TYPE_SER_C]) &&
    irq_level_o.serial_d == $past(wr_byte[`GCR_BIT_TYPE_SER_D]) &&
    irq_level_o.smi == $past(wr_byte[`GCR_BIT_TYPE_SMI]))
    else $error("serial C/D or SMI type not taken");
  a_gated_read_zero: assert property (
    req_new && !wb_req_i.we && is_gated(acc_idx) && !gate_on |=>
    wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("closed gated register read not zero");
  a_pins33_select: assert property (
    !strap_result_q[`GCR_BIT_PORT80_STRAP] && pin_func_q[`GCR_BIT_PINS33_SER] |->
    pin_mux_o.pins33_40 == gcr_pkg::gcr_pins33_serial_c)
    else $error("pins 33-40 serial select wrong");
  a_port80_route: assert property (
    strap_result_q[`GCR_BIT_PORT80_STRAP] |->
    pin_mux_o.pins33_40 == gcr_pkg::gcr_pins33_gpio_port80)
    else $error("port80 route not selected");
  a_pins41_select: assert property (
    pin_func_q[`GCR_BIT_PINS41_SER] |-> pin_mux_o.pins41_48 == gcr_pkg::gcr_pins41_serial_d)
    else $error("pins 41-48 serial select wrong");
  a_pin_func_write: assert property (
    pf_hit |=> pin_func_q == $past(wr_byte))
    else $error("pin function register not stored");
  a_gopt_stby_write: assert property (
    gs_hit |=> gopt_stby_q == $past(wr_byte))
    else $error("standby global option not stored");
  a_id_low_read: assert property (
    req_new && !wb_req_i.we && acc_idx == `GCR_IDX_ID_LOW |=>
    wb_ack_o && wb_dat_o[7:0] == {CHIP_ID_LOW_FIXED, CHIP_REVISION})
    else $error("chip id low read wrong");
  a_power_serial_write: assert property (
    wr_fire && acc_idx == `GCR_IDX_POWER_DOWN |=>
    serial_a_power_on_o == $past(wr_byte[`GCR_BIT_PD_SER_A]) &&
    serial_b_power_on_o == $past(wr_byte[`GCR_BIT_PD_SER_B]))
    else $error("serial power bits not taken");
  a_pnp_write: assert property (
    wr_fire && acc_idx == `GCR_IDX_ADDR_DEF |=>
    pnp_default_select_o == $past(wr_byte[`GCR_BIT_PNP_DEFAULT]))
    else $error("address default bit not taken");
  a_strap_capture: assert property (
    !strap_taken_q && !gopt_hit |=>
    gopt_strap_q[`GCR_BIT_OPT_STRAP] == $past(global_option_strap_i))
    else $error("option strap not captured");
  a_soft_reset_quiet: assert property (
    !(soft_hit && wr_byte[`GCR_BIT_SOFT_RESET]) |=> !soft_reset_o)
    else $error("soft reset pulse without write");

  c_gated_write: cover property (wr_fire && gate_on && is_gated(acc_idx));
  c_soft_reset: cover property (soft_reset_o);
  c_pin32_gpio: cover property (pin_mux_o.pin32 == gcr_pkg::gcr_pin32_gpio);
  c_read_back: cover property (req_new && !wb_req_i.we ##1 wb_ack_o);
  c_gated_read_closed: cover property (req_new && !wb_req_i.we && is_gated(acc_idx) && !gate_on);
endmodule

// File: src/gcr_map.svh
// Purpose: register indices, bit positions and reset values of the global config bank
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef GCR_MAP_SVH
`define GCR_MAP_SVH
`define GCR_IDX_SOFT_RESET 8'h02
`define GCR_IDX_LDN 8'h07
`define GCR_IDX_TYPE_A 8'h10
`define GCR_IDX_TYPE_B 8'h11
`define GCR_IDX_POL_HIGH 8'h13
`define GCR_IDX_POL_LOW 8'h14
`define GCR_IDX_PIN_FUNC 8'h1C
`define GCR_IDX_ID_HIGH 8'h20
`define GCR_IDX_ID_LOW 8'h21
`define GCR_IDX_POWER_DOWN 8'h22
`define GCR_IDX_ADDR_DEF 8'h24
`define GCR_IDX_TRISTATE 8'h25
`define GCR_IDX_GOPT_STRAP 8'h26
`define GCR_IDX_GOPT_STBY 8'h27
`define GCR_IDX_STRAP_RESULT 8'h2F
`define GCR_RST_ONES 8'hFF
`define GCR_RST_ZERO 8'h00
`define GCR_RST_PIN_FUNC 8'h10
`define GCR_BIT_SOFT_RESET 0
`define GCR_BIT_TYPE_SER_A 5
`define GCR_BIT_TYPE_SER_B 4
`define GCR_BIT_TYPE_WDT 6
`define GCR_BIT_TYPE_SER_C 5
`define GCR_BIT_TYPE_SER_D 4
`define GCR_BIT_TYPE_SMI 1
`define GCR_BIT_GATE 4
`define GCR_BIT_OPT_STRAP 6
`define GCR_BIT_PIN32_GPIO 4
`define GCR_BIT_PINS33_SER 3
`define GCR_BIT_PINS41_SER 2
`define GCR_BIT_PIN32_RSVD 2
`define GCR_BIT_PD_SER_B 5
`define GCR_BIT_PD_SER_A 4
`define GCR_BIT_PD_IMMEDIATE 1
`define GCR_BIT_PNP_DEFAULT 0
`define GCR_BIT_TRI_D 5
`define GCR_BIT_TRI_C 4
`define GCR_BIT_TRI_B 3
`define GCR_BIT_TRI_A 2
`define GCR_BIT_PORT80_STRAP 3
`endif

// File: src/gcr_pkg.sv
// Purpose: types shared by the global config bank and its users
// Assumes: classic Wishbone, 32-bit data, 8-bit byte address
// Notes: none
package gcr_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } gcr_wb_req_t;
  typedef enum logic [1:0] {gcr_pin32_clock, gcr_pin32_gpio, gcr_pin32_reserved} gcr_pin32_t;
  typedef enum logic [1:0] {gcr_pins33_gpio, gcr_pins33_serial_c, gcr_pins33_gpio_port80}
    gcr_pins33_t;
  typedef enum logic {gcr_pins41_gpio, gcr_pins41_serial_d} gcr_pins41_t;
  typedef struct packed {
    gcr_pin32_t pin32;
    gcr_pins33_t pins33_40;
    gcr_pins41_t pins41_48;
  } gcr_pin_mux_t;
  typedef struct packed {
    logic serial_a;
    logic serial_b;
    logic serial_c;
    logic serial_d;
    logic watchdog_timeout_irq;
    logic smi;
  } gcr_irq_level_t;
endpackage

// File: verification/gcr_host_model.sv
// Purpose: host bus master facing the global config bank
// Assumes: classic Wishbone single cycles, byte address is index * 4
// Notes: released we, address and data lines carry the inverse of the last value; cyc, stb and sel drop to zero
`timescale 1ns/1ns
module gcr_host_model (
  input wire logic clock_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output gcr_pkg::gcr_wb_req_t wb_req_o
);
  initial wb_req_o = '0;

  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd);
    @(posedge clock_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: {idx[5:0], 2'b00},
      dat: {24'h000000, wd}};
    @(posedge clock_i);
    while (wb_ack_i !== 1'b1)
      @(posedge clock_i);
    rd = wb_dat_i[7:0];
    // Stale lines must not look like a valid request
    wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: 4'h0, adr: ~wb_req_o.adr,
      dat: ~wb_req_o.dat};
  endtask
endmodule

// File: verification/global_config_register_bank_tb.sv
// Purpose: self-checking bench for the global config bank
// Assumes: both resets applied together at start
// Notes: watchdog ends a hung run
`timescale 1ns/1ns
module global_config_register_bank_tb;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic standby_reset_n = 1'b0;
  logic opt_strap = 1'b0;
  logic p80_strap = 1'b1;
  gcr_pkg::gcr_wb_req_t wb_req;
  logic [31:0] wb_dat;
  logic wb_ack, soft_reset, pwr_a, pwr_b, immediate_power_down, pnp, tri_a, tri_b, tri_c, tri_d;
  logic [7:0] ldn;
  logic [15:0] irq_pol;
  gcr_pkg::gcr_irq_level_t irq_level;
  gcr_pkg::gcr_pin_mux_t pin_mux;
  int mismatches = 0;
  int cmp_count = 0;
  int sr_pulses = 0;

  always #50 clock_i = ~clock_i;
  always @(posedge clock_i)
    if (soft_reset === 1'b1)
      sr_pulses++;

  gcr_host_model u_host (.clock_i(clock_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_dat),
    .wb_req_o(wb_req));
  gcr_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .standby_power_good_reset_n_i(standby_reset_n), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .global_option_strap_i(opt_strap),
    .port80_serial_out_strap_i(p80_strap), .soft_reset_o(soft_reset),
    .logical_device_o(ldn), .irq_level_o(irq_level), .irq_polarity_low_o(irq_pol),
    .pin_mux_o(pin_mux), .serial_a_power_on_o(pwr_a), .serial_b_power_on_o(pwr_b),
    .immediate_power_down_o(immediate_power_down), .pnp_default_select_o(pnp),
    .serial_a_tristate_o(tri_a), .serial_b_tristate_o(tri_b),
    .serial_c_tristate_o(tri_c), .serial_d_tristate_o(tri_d));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    u_host.xfer(1'b1, idx, d, r);
    // Let the register update land before outputs are judged
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] r;
    u_host.xfer(1'b0, idx, 8'h00, r);
    chk({24'h000000, r}, {24'h000000, e});
  endtask

  task automatic t_defaults;
    rd(8'h07, 8'h00);
    rd(8'h1C, 8'h10);
    rd(8'h22, 8'hFF);
    rd(8'h24, 8'h00);
    rd(8'h25, 8'h00);
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h00);
    rd(8'h2F, 8'h08);
    rd(8'h20, 8'hA5);
    rd(8'h21, 8'h61);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'hA5);
    rd(8'h3E, 8'h00);
    rd(8'h10, 8'h00);
    chk({16'h0000, irq_pol}, 32'h0000FFFF);
    chk({26'h0, irq_level}, 32'h0000003F);
  endtask

  task automatic t_irq;
    wr(8'h10, 8'h20);
    wr(8'h26, 8'h10);
    rd(8'h10, 8'hFF);
    wr(8'h10, 8'h20);
    wr(8'h11, 8'h42);
    wr(8'h13, 8'hA5);
    wr(8'h14, 8'h3C);
    rd(8'h10, 8'h20);
    rd(8'h11, 8'h42);
    chk({26'h0, irq_level}, 32'h00000023);
    chk({16'h0000, irq_pol}, 32'h0000A53C);
    wr(8'h11, 8'h30);
    chk({26'h0, irq_level}, 32'h0000002C);
    wr(8'h26, 8'h00);
    rd(8'h13, 8'h00);
  endtask

  task automatic t_ctrl;
    int n;
    n = sr_pulses;
    wr(8'h02, 8'h01);
    repeat (2) @(posedge clock_i);
    chk(sr_pulses - n, 1);
    wr(8'h02, 8'hFE);
    repeat (2) @(posedge clock_i);
    chk(sr_pulses - n, 1);
    rd(8'h02, 8'h00);
    wr(8'h07, 8'h5A);
    chk({24'h000000, ldn}, 32'h0000005A);
    wr(8'h22, 8'h12);
    chk({pwr_a, pwr_b, immediate_power_down}, 3'b100);
    wr(8'h22, 8'h20);
    chk({pwr_a, pwr_b, immediate_power_down}, 3'b011);
    wr(8'h24, 8'h01);
    chk(pnp, 1'b1);
    wr(8'h25, 8'h14);
    chk({tri_a, tri_b, tri_c, tri_d}, 4'b1010);
    wr(8'h25, 8'h28);
    chk({tri_a, tri_b, tri_c, tri_d}, 4'b0101);
  endtask

  task automatic pm(input logic [7:0] r27, input logic [7:0] r1c, input logic [7:0] r2f,
    input gcr_pkg::gcr_pin_mux_t e);
    wr(8'h27, r27);
    wr(8'h1C, r1c);
    wr(8'h2F, r2f);
    chk(pin_mux, e);
  endtask

  task automatic t_pinmux;
    pm(8'h00, 8'h00, 8'h00, {gcr_pkg::gcr_pin32_clock, gcr_pkg::gcr_pins33_gpio,
      gcr_pkg::gcr_pins41_gpio});
    pm(8'h00, 8'h1C, 8'h00, {gcr_pkg::gcr_pin32_gpio, gcr_pkg::gcr_pins33_serial_c,
      gcr_pkg::gcr_pins41_serial_d});
    pm(8'h04, 8'h18, 8'h08, {gcr_pkg::gcr_pin32_reserved, gcr_pkg::gcr_pins33_gpio_port80,
      gcr_pkg::gcr_pins41_gpio});
    pm(8'h04, 8'h00, 8'h00, {gcr_pkg::gcr_pin32_reserved, gcr_pkg::gcr_pins33_gpio,
      gcr_pkg::gcr_pins41_gpio});
  endtask

  task automatic t_busreset;
    wr(8'h1C, 8'h04);
    wr(8'h27, 8'h04);
    wr(8'h2F, 8'h08);
    wr(8'h07, 8'h33);
    opt_strap <= 1'b1;
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rd(8'h07, 8'h00);
    rd(8'h22, 8'hFF);
    rd(8'h26, 8'h40);
    rd(8'h1C, 8'h04);
    rd(8'h27, 8'h04);
    rd(8'h2F, 8'h08);
    chk({16'h0000, irq_pol}, 32'h0000FFFF);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    standby_reset_n <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_defaults();
    t_irq();
    t_ctrl();
    t_pinmux();
    t_busreset();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock_i);
    mismatches++;
    final_report();
  end
endmodule
